// ==== vlpc_defs.svh ====
`ifndef VLPC_DEFS_SVH
`define VLPC_DEFS_SVH
`define VLPC_MCLK_MHZ       25
// register offsets
`define VLPC_OFS_RATE       4'h0
`define VLPC_OFS_SPREAD     4'h1
`define VLPC_OFS_STO        4'h2
`define VLPC_OFS_ETO        4'h3
`define VLPC_OFS_EDGE       4'h4
`define VLPC_OFS_PERIPH     4'h8
`define VLPC_OFS_PRBS_IO    4'h9
`define VLPC_OFS_IO_DIR     4'hA
`define VLPC_OFS_IO_VAL     4'hB
`define VLPC_OFS_FILT       4'hD
`define VLPC_OFS_LOCK       4'hE
`define VLPC_OFS_PAR_CNT_LO 4'hA
`define VLPC_OFS_PAR_CNT_HI 4'hB
`define VLPC_OFS_PRBS_CNT   4'hC
`define VLPC_OFS_CHAN_FLAGS 4'hD
// serializer reset values, offsets 0..14
`define VLPC_SER_RST {8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, \
	8'hF8, 8'hFF, 8'hFA, 8'h28, 8'hA0, 8'hA0, 8'h1F, 8'hB5}
`define VLPC_SER_EDGE_REM   8'h30
// writable bits; reserved and read-only bits are zero
`define VLPC_SER_WMASK {8'h00, 8'h03, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
	8'hFF, 8'hFF, 8'hFF, 8'hBD, 8'hFF, 8'hFF, 8'hE0, 8'hFF}
// deserializer reset values, offsets 0..9
`define VLPC_DES_RST {8'h00, 8'h10, 8'h00, 8'hFF, 8'hF8, 8'h20, 8'hA0, \
	8'hA0, 8'h00, 8'hB5}
`define VLPC_DES_WMASK {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE9, 8'hFF, \
	8'hFF, 8'hF8, 8'hFF}
// field positions
`define VLPC_RATE_PAR_BIT   3
`define VLPC_EDGE_VSYNC_BIT 7
`define VLPC_EDGE_PCLK_BIT  5
`define VLPC_EDGE_PD_BIT    4
`define VLPC_EDGE_SER_BIT   3
`define VLPC_EDGE_PRBS_BIT  0
`define VLPC_AUTO_CLR_BIT   5
// handshake lengths in words
`define VLPC_HSK_SHORT      11'd546
`define VLPC_HSK_LONG       11'd1090
// glitch rejection widths and derived cycles, rounded down, at least one
`define VLPC_GF_SLOW_NS     100
`define VLPC_GF_MID_NS      50
`define VLPC_GF_FAST_NS     10
`define VLPC_NS2CYC(ns) \
	((((ns) * `VLPC_MCLK_MHZ) / 1000) < 1 ? 1 : (((ns) * `VLPC_MCLK_MHZ) / 1000))
`define VLPC_GF_SLOW_CYC    `VLPC_NS2CYC(`VLPC_GF_SLOW_NS)
`define VLPC_GF_MID_CYC     `VLPC_NS2CYC(`VLPC_GF_MID_NS)
`define VLPC_GF_FAST_CYC    `VLPC_NS2CYC(`VLPC_GF_FAST_NS)
`endif

// ==== vlpc_pkg.sv ====
package vlpc_pkg;
	typedef enum logic [2:0] {
		PH_VIDEO = 3'b001,
		PH_CTRL  = 3'b010,
		PH_HSK   = 3'b100
	} vlpc_phase_t;
	typedef struct packed {
		logic [15:0] data;
		logic        hsync;
		logic        vsync;
	} vlpc_pix_t;
	typedef struct packed {
		logic [4:0]  len;
		logic [21:0] bits;
	} vlpc_word_t;
endpackage : vlpc_pkg

// ==== vlpc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "vlpc_defs.svh"
module vlpc_top (
	input  wire logic              mclk_i,
	input  wire logic              rst_b_i,
	input  wire logic              remote_powerup_select_i,
	input  wire logic              reg_bank_i,
	input  wire logic [3:0]        reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_wdata_i,
	output logic [7:0]             reg_rdata_o,
	input  wire vlpc_pkg::vlpc_pix_t pix_i,
	input  wire logic              pix_valid_i,
	output logic                   pix_ready_o,
	output vlpc_pkg::vlpc_word_t   word_o,
	output logic                   word_valid_o,
	input  wire logic              word_ready_i,
	input  wire logic              ecu_activity_i,
	output logic                   ctrl_channel_open_flag_o,
	output logic                   handshake_pattern_o,
	output logic                   pixclk_rise_o,
	output logic                   power_down_o,
	input  wire logic              video_par_err_i,
	input  wire logic              prbs_err_i,
	input  wire logic [4:0]        chan_err_i,
	input  wire logic              pll_locked_i,
	input  wire logic              word_aligned_i,
	output logic                   lock_o,
	output logic                   error_n_o,
	output logic [9:0]             io_line_o,
	output logic [9:0]             io_line_oe_o,
	input  wire logic              sda_i,
	output logic                   sda_filt_o
);
	localparam logic [14:0][7:0] SER_RST = `VLPC_SER_RST;
	localparam logic [14:0][7:0] SER_WM  = `VLPC_SER_WMASK;
	localparam logic [9:0][7:0]  DES_RST = `VLPC_DES_RST;
	localparam logic [9:0][7:0]  DES_WM  = `VLPC_DES_WMASK;

	logic [7:0]  ser_q [15];
	logic [7:0]  des_q [10];
	logic        boot_q;

	// register file
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			boot_q <= 1'b0;
		else
			boot_q <= 1'b1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 15; gi++) begin : g_ser
			wire sel = reg_wr_i && !reg_bank_i && reg_addr_i == 4'(gi);
			always_ff @(posedge mclk_i or negedge rst_b_i) begin
				if (!rst_b_i)
					ser_q[gi] <= SER_RST[gi];
				else if (gi == 4 && !boot_q && remote_powerup_select_i)
					ser_q[gi] <= `VLPC_SER_EDGE_REM;
				else if (sel)
					ser_q[gi] <= (ser_q[gi] & ~SER_WM[gi])
						| (reg_wdata_i & SER_WM[gi]);
			end
		end
		for (gi = 0; gi < 10; gi++) begin : g_des
			wire sel = reg_wr_i && reg_bank_i && reg_addr_i == 4'(gi);
			always_ff @(posedge mclk_i or negedge rst_b_i) begin
				if (!rst_b_i)
					des_q[gi] <= DES_RST[gi];
				else if (sel)
					des_q[gi] <= (des_q[gi] & ~DES_WM[gi])
						| (reg_wdata_i & DES_WM[gi]);
			end
		end
	endgenerate

	// deserializer error counters and flags
	logic [15:0] par_cnt_q;
	logic [7:0]  prbs_cnt_q;
	logic [4:0]  chan_flags_q;
	logic        err_main_q;
	logic        err_prbs_q;
	wire auto_clr = des_q[`VLPC_OFS_SPREAD][`VLPC_AUTO_CLR_BIT];
	wire err_rd = reg_rd_i && reg_bank_i
		&& reg_addr_i >= `VLPC_OFS_PAR_CNT_LO
		&& reg_addr_i <= `VLPC_OFS_CHAN_FLAGS;
	wire cnt_clr = err_rd && !auto_clr;
	wire prbs_on = des_q[`VLPC_OFS_EDGE][`VLPC_EDGE_PRBS_BIT];
	wire [15:0] par_limit = {des_q[9], des_q[8]};
	wire par_sat = &par_cnt_q;
	wire prbs_sat = &prbs_cnt_q;
	wire [15:0] par_cnt_d = (cnt_clr ? 16'h0000 : par_cnt_q)
		+ 16'(video_par_err_i && (cnt_clr || !par_sat));
	wire [7:0] prbs_cnt_d = (cnt_clr ? 8'h00 : prbs_cnt_q)
		+ 8'(prbs_err_i && (cnt_clr || !prbs_sat));
	wire [4:0] chan_flags_d = (cnt_clr ? 5'h00 : chan_flags_q) | chan_err_i;
	// set wins over the read clear
	wire err_main_d = (video_par_err_i && par_cnt_d >= par_limit)
		|| (|chan_err_i) || (err_main_q && !err_rd);
	wire err_prbs_d = prbs_on && (prbs_err_i || err_prbs_q);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			par_cnt_q    <= 16'h0000;
			prbs_cnt_q   <= 8'h00;
			chan_flags_q <= 5'h00;
			err_main_q   <= 1'b0;
			err_prbs_q   <= 1'b0;
			error_n_o    <= 1'b1;
			lock_o       <= 1'b0;
		end else begin
			par_cnt_q    <= par_cnt_d;
			prbs_cnt_q   <= prbs_cnt_d;
			chan_flags_q <= chan_flags_d;
			err_main_q   <= err_main_d;
			err_prbs_q   <= err_prbs_d;
			error_n_o    <= !(err_main_d || err_prbs_d);
			lock_o       <= pll_locked_i && word_aligned_i;
		end
	end

	// register read port
	wire [7:0] ser_rd = reg_addr_i == `VLPC_OFS_LOCK ? {7'h00, lock_o}
		: reg_addr_i < 4'hF ? ser_q[reg_addr_i] : 8'h00;
	wire [7:0] des_rd = reg_addr_i < 4'hA ? des_q[reg_addr_i]
		: reg_addr_i == `VLPC_OFS_PAR_CNT_LO ? par_cnt_q[7:0]
		: reg_addr_i == `VLPC_OFS_PAR_CNT_HI ? par_cnt_q[15:8]
		: reg_addr_i == `VLPC_OFS_PRBS_CNT ? prbs_cnt_q
		: reg_addr_i == `VLPC_OFS_CHAN_FLAGS ? {3'h0, chan_flags_q}
		: 8'h00;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= reg_bank_i ? des_rd : ser_rd;
	end

	// phase sequencing
	vlpc_pkg::vlpc_phase_t phase_q;
	vlpc_pkg::vlpc_phase_t phase_d;
	logic        vsync_q;
	logic        act_seen_q;
	logic [15:0] pre_q;
	logic [3:0]  tcnt_q;
	logic [10:0] hsk_q;
	wire [7:0] edge_r = ser_q[`VLPC_OFS_EDGE];
	wire vs_rise = edge_r[`VLPC_EDGE_VSYNC_BIT];
	wire vs_edge = vs_rise ? (pix_i.vsync && !vsync_q)
		: (!pix_i.vsync && vsync_q);
	wire [7:0] tmr_r = act_seen_q ? ser_q[`VLPC_OFS_ETO]
		: ser_q[`VLPC_OFS_STO];
	wire [15:0] pre_top = 16'((17'h00001 << tmr_r[7:4]) - 17'h00001);
	wire tick = pre_q == pre_top;
	wire tmr_done = tick && tcnt_q == tmr_r[3:0] && !ecu_activity_i;
	wire hsk_long = |ser_q[`VLPC_OFS_SPREAD][7:5];
	wire [10:0] hsk_len = hsk_long ? `VLPC_HSK_LONG : `VLPC_HSK_SHORT;
	wire hsk_last = hsk_q == hsk_len - 11'd1;

	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			vlpc_pkg::PH_VIDEO:
				if (pix_valid_i && vs_edge)
					phase_d = vlpc_pkg::PH_CTRL;
			vlpc_pkg::PH_CTRL:
				if (tmr_done)
					phase_d = vlpc_pkg::PH_HSK;
			vlpc_pkg::PH_HSK:
				if (hsk_last)
					phase_d = vlpc_pkg::PH_VIDEO;
			default:
				phase_d = vlpc_pkg::PH_VIDEO;
		endcase
	end

	wire in_ctrl = phase_q == vlpc_pkg::PH_CTRL;
	wire tmr_rst = !in_ctrl || ecu_activity_i;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_q    <= vlpc_pkg::PH_VIDEO;
			vsync_q    <= 1'b0;
			act_seen_q <= 1'b0;
			pre_q      <= 16'h0000;
			tcnt_q     <= 4'h0;
			hsk_q      <= 11'h000;
			ctrl_channel_open_flag_o <= 1'b0;
			handshake_pattern_o      <= 1'b0;
		end else begin
			phase_q <= phase_d;
			if (pix_valid_i)
				vsync_q <= pix_i.vsync;
			act_seen_q <= in_ctrl && (act_seen_q || ecu_activity_i);
			pre_q  <= (tmr_rst || tick) ? 16'h0000 : pre_q + 16'h0001;
			tcnt_q <= tmr_rst ? 4'h0 : tcnt_q + 4'(tick);
			hsk_q  <= phase_q == vlpc_pkg::PH_HSK ? hsk_q + 11'h001
				: 11'h000;
			ctrl_channel_open_flag_o <= phase_d == vlpc_pkg::PH_CTRL;
			handshake_pattern_o <= phase_d == vlpc_pkg::PH_HSK;
		end
	end

	// word building
	wire [7:0] rate_r = ser_q[`VLPC_OFS_RATE];
	wire par_en = rate_r[`VLPC_RATE_PAR_BIT];
	wire [2:0] wcode = rate_r[2] ? 3'd4 : {1'b0, rate_r[1:0]};
	wire [4:0] vbits = 5'd8 + {1'b0, wcode, 1'b0};
	wire [15:0] vmask = 16'hFFFF >> (5'd16 - vbits);
	wire [15:0] vdat = pix_i.data & vmask;
	wire [4:0] ones = 5'($countones(vdat));
	wire bal_hi = ones > (vbits >> 1);
	wire bal_lo = !bal_hi;
	wire [15:0] vcode = bal_hi ? (~vdat & vmask) : vdat;
	wire [19:0] base = {vcode, pix_i.vsync, pix_i.hsync, bal_hi, bal_lo};
	wire par_bit = ^base;
	wire [21:0] word_bits = par_en ? {base, !par_bit, par_bit}
		: {2'b00, base};
	wire [4:0] word_len = vbits + 5'd4 + (par_en ? 5'd2 : 5'd0);
	vlpc_pkg::vlpc_word_t word_in;
	assign word_in = {word_len, word_bits};
	wire ser_on = edge_r[`VLPC_EDGE_SER_BIT] && !edge_r[`VLPC_EDGE_PD_BIT];

	// two-entry buffer; words only enter in the video phase, but drain in any phase
	vlpc_pkg::vlpc_word_t tail_q;
	logic tail_v_q;
	wire video = phase_q == vlpc_pkg::PH_VIDEO;
	wire push = pix_valid_i && pix_ready_o && video && ser_on;
	wire pop = word_valid_o && word_ready_i;
	wire head_free = !word_valid_o || pop;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_o       <= '0;
			word_valid_o <= 1'b0;
			tail_q       <= '0;
			tail_v_q     <= 1'b0;
			pix_ready_o  <= 1'b0;
		end else begin
			if (head_free) begin
				word_o       <= tail_v_q ? tail_q : word_in;
				word_valid_o <= tail_v_q || push;
			end
			if (push && !(head_free && !tail_v_q))
				tail_q <= word_in;
			tail_v_q <= (tail_v_q && !head_free)
				|| (push && !(head_free && !tail_v_q))
				|| (tail_v_q && head_free && push);
			pix_ready_o <= !(tail_v_q && !head_free) && !(push && !head_free);
		end
	end

	// glitch filter on the peripheral data line
	logic       sda_q;
	logic [2:0] gf_q;
	wire [1:0] band = ser_q[`VLPC_OFS_PERIPH][1:0];
	wire [2:0] gf_len = band == 2'b00 ? 3'(`VLPC_GF_SLOW_CYC)
		: band == 2'b01 ? 3'(`VLPC_GF_MID_CYC) : 3'(`VLPC_GF_FAST_CYC);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sda_q      <= 1'b1;
			gf_q       <= 3'h0;
			sda_filt_o <= 1'b1;
		end else begin
			sda_q <= sda_i;
			gf_q  <= (sda_q == sda_filt_o) ? 3'h0 : gf_q + 3'h1;
			if (sda_q != sda_filt_o && gf_q + 3'h1 >= gf_len)
				sda_filt_o <= sda_q;
		end
	end

	assign io_line_oe_o = {ser_q[9][3:2], ser_q[`VLPC_OFS_IO_DIR]};
	assign io_line_o = {ser_q[9][1:0], ser_q[`VLPC_OFS_IO_VAL]};
	assign power_down_o = edge_r[`VLPC_EDGE_PD_BIT];
	assign pixclk_rise_o = des_q[`VLPC_OFS_EDGE][`VLPC_EDGE_PCLK_BIT];

	// checks
	logic [10:0] hsk_seen_q;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			hsk_seen_q <= 11'h000;
		else
			hsk_seen_q <= phase_q == vlpc_pkg::PH_HSK ? hsk_q : 11'h000;
	end

	sequence s_hsk_end;
		phase_q == vlpc_pkg::PH_HSK ##1 phase_q == vlpc_pkg::PH_VIDEO;
	endsequence

	vsync_enter_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		video && pix_valid_i && vs_edge |=> in_ctrl && ctrl_channel_open_flag_o)
		else $error("active vsync edge did not open the channel");
	open_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ctrl_channel_open_flag_o == in_ctrl)
		else $error("open flag disagrees with phase");
	hsk_length_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		s_hsk_end |-> hsk_seen_q == hsk_len - 11'd1)
		else $error("handshake length wrong");
	timer_restart_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		in_ctrl && ecu_activity_i |=> tcnt_q == 4'h0 && pre_q == 16'h0000)
		else $error("activity did not restart timers");
	close_timer_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		in_ctrl && tmr_done |=> phase_q == vlpc_pkg::PH_HSK ##1
		handshake_pattern_o)
		else $error("channel did not close on terminal count");
	half_duplex_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!video |-> !push)
		else $error("video word taken outside video phase");
	parity_order_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		push && par_en |-> word_in.bits[1] == !word_in.bits[0]
		&& word_in.bits[3:2] == {bal_hi, bal_lo})
		else $error("parity bits not ahead of balance bits");
	balance_first_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		push && !par_en |-> word_in.bits[1:0] == {bal_hi, bal_lo}
		&& word_in.len == vbits + 5'd4)
		else $error("balance bits not first");
	error_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		|chan_err_i |=> !error_n_o)
		else $error("error pin not low after channel error");
	lock_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!pll_locked_i || !word_aligned_i |=> !lock_o)
		else $error("lock high without lock and alignment");
	read_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		cnt_clr && !video_par_err_i |=> par_cnt_q == 16'h0000)
		else $error("error read did not clear count");
endmodule : vlpc_top
`default_nettype wire

// ==== vlpc_link_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
// far end of the serial link: takes one word per handshake, stalls on demand
module vlpc_link_sink (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 stall_i,
	input  wire vlpc_pkg::vlpc_word_t word_i,
	input  wire logic                 word_valid_i,
	output logic                      word_ready_o,
	output logic                      got_o,
	output vlpc_pkg::vlpc_word_t      got_word_o
);
	// a word counts only at an edge where valid and ready are both high
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_ready_o <= 1'b0;
			got_o        <= 1'b0;
			got_word_o   <= '0;
		end else begin
			got_o        <= word_valid_i & word_ready_o;
			got_word_o   <= word_i;
			word_ready_o <= ~stall_i;
		end
	end
endmodule : vlpc_link_sink
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                 mclk_i = 1'b0;
	logic                 rst_b_i = 1'b0;
	logic                 strap = 1'b0, bank = 1'b0, wr_s = 1'b0;
	logic                 rd_s = 1'b0, pvalid = 1'b0, stall = 1'b0;
	logic                 act = 1'b0, perr = 1'b0, berr = 1'b0;
	logic                 pll = 1'b0, algn = 1'b0, sda = 1'b1;
	logic [3:0]           addr = 4'h0;
	logic [7:0]           wdata = 8'h00;
	logic [4:0]           cerr = 5'h00;
	vlpc_pkg::vlpc_pix_t  pix = '0;
	logic [7:0]           rdata;
	logic                 pready, wvalid, wready, got, open, handshake_pattern;
	logic                 prise, pd, lock, err_n, sfilt;
	logic [9:0]           io, ioe;
	vlpc_pkg::vlpc_word_t word, got_word, ew;
	vlpc_pkg::vlpc_word_t expq[$];
	logic                 vid_on = 1'b0, par_on = 1'b0;
	int                   seed = 65, bad_count = 0, samples_checked = 0;
	logic [7:0] ser_rst [15] = '{8'hB5, 8'h1F, 8'hA0, 8'hA0, 8'h28, 8'hFA,
		8'hFF, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00};
	logic [7:0] des_rst [14] = '{8'hB5, 8'h00, 8'hA0, 8'hA0, 8'h20, 8'hF8,
		8'hFF, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	vlpc_top uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.remote_powerup_select_i(strap), .reg_bank_i(bank),
		.reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .pix_i(pix),
		.pix_valid_i(pvalid), .pix_ready_o(pready), .word_o(word),
		.word_valid_o(wvalid), .word_ready_i(wready), .ecu_activity_i(act),
		.ctrl_channel_open_flag_o(open), .handshake_pattern_o(handshake_pattern),
		.pixclk_rise_o(prise), .power_down_o(pd), .video_par_err_i(perr),
		.prbs_err_i(berr), .chan_err_i(cerr), .pll_locked_i(pll),
		.word_aligned_i(algn), .lock_o(lock), .error_n_o(err_n),
		.io_line_o(io), .io_line_oe_o(ioe), .sda_i(sda), .sda_filt_o(sfilt));

	vlpc_link_sink link (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .stall_i(stall),
		.word_i(word), .word_valid_i(wvalid), .word_ready_o(wready),
		.got_o(got), .got_word_o(got_word));

	initial begin
		forever #20 mclk_i = ~mclk_i;
	end

	task automatic conclude();
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic b, input logic [3:0] a, input logic [7:0] d);
		bank  <= b;
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge mclk_i);
		wr_s  <= 1'b0;
		@(posedge mclk_i);
	endtask : wr

	// read data stands until the next read, so it is sampled two edges after the capturing edge
	task automatic rdc(input logic b, input logic [3:0] a, input logic [7:0] e);
		bank <= b;
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_i);
		rd_s <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk(rdata, e);
	endtask : rdc

	task automatic do_reset(input logic s);
		rst_b_i <= 1'b0;
		strap   <= s;
		repeat (6) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask : do_reset

	// high balance bit marks inverted data; parity pair covers the whole word
	function automatic vlpc_pkg::vlpc_word_t exp_word(
			input vlpc_pkg::vlpc_pix_t p, input logic par);
		vlpc_pkg::vlpc_word_t w;
		logic [19:0]          b;
		logic                 inv;
		inv = $countones(p.data) > 8;
		b = {inv ? ~p.data : p.data, p.vsync, p.hsync, inv, !inv};
		w.len = par ? 5'd22 : 5'd20;
		w.bits = par ? {b, !(^b), ^b} : {2'b00, b};
		return w;
	endfunction : exp_word

	always @(posedge mclk_i) begin
		if (vid_on && pvalid && pready)
			expq.push_back(exp_word(pix, par_on));
		if (got && vid_on && expq.size() > 0) begin
			ew = expq.pop_front();
			chk({got_word.len, got_word.bits}, {ew.len, ew.bits});
			if (par_on)
				chk(got_word.bits[1], !got_word.bits[0]);
		end
	end

	task automatic stream(input logic par);
		par_on = par;
		wr(1'b0, 4'h0, par ? 8'hBD : 8'hB5);
		vid_on = 1'b1;
		pvalid <= 1'b1;
		for (int i = 0; i < 80; i++) begin
			if (!pvalid || pready)
				pix <= {16'($random(seed)), 1'($random(seed)), 1'b1};
			stall <= (i >= 30 && i < 40) || ($random(seed) % 3 == 0);
			if (i == 39)
				chk(pready, 1'b0);
			@(posedge mclk_i);
		end
		pvalid <= 1'b0;
		stall  <= 1'b0;
		repeat (10) @(posedge mclk_i);
		chk(expq.size(), 0);
		vid_on = 1'b0;
	endtask : stream

	task automatic phase(input logic busy, input int hsk_len);
		int n;
		n = 0;
		pvalid    <= 1'b1;
		pix.vsync <= 1'b1;
		repeat (2) @(posedge mclk_i);
		pix.vsync <= 1'b0;
		repeat (2) @(posedge mclk_i);
		pvalid <= 1'b0;
		chk(open, 1'b1);
		while (open === 1'b1 && n < 300) begin
			act <= busy && n == 5;
			n++;
			@(posedge mclk_i);
		end
		act <= 1'b0;
		chk(n >= (busy ? 19 : 13) && n <= (busy ? 25 : 19), 1);
		n = 0;
		while (handshake_pattern === 1'b1 && n < 2000) begin
			n++;
			@(posedge mclk_i);
		end
		chk(n, hsk_len);
		chk(open, 1'b0);
	endtask : phase

	task automatic glitch(input int w, input logic e);
		logic seen;
		seen = 1'b0;
		sda <= 1'b0;
		repeat (w) @(posedge mclk_i);
		sda <= 1'b1;
		repeat (6) begin
			@(posedge mclk_i);
			if (sfilt === 1'b0)
				seen = 1'b1;
		end
		chk(seen, e);
	endtask : glitch

	initial begin
		logic [31:0] r;
		do_reset(1'b1);
		chk(pd, 1'b1);
		rdc(1'b0, 4'h4, 8'h30);
		do_reset(1'b0);
		chk(pd, 1'b0);
		for (int a = 0; a < 15; a++)
			rdc(1'b0, 4'(a), ser_rst[a]);
		for (int a = 0; a < 14; a++)
			rdc(1'b1, 4'(a), des_rst[a]);
		chk({prise, io, ioe}, {1'b1, 20'h00000});
		rdc(1'b0, 4'hF, 8'h00);
		wr(1'b1, 4'hC, 8'hFF);
		rdc(1'b1, 4'hC, 8'h00);
		wr(1'b1, 4'h4, 8'h00);
		chk(prise, 1'b0);
		wr(1'b1, 4'h4, 8'h20);
		repeat (4) begin
			r = $random(seed);
			wr(1'b0, 4'hA, r[7:0]);
			wr(1'b0, 4'hB, r[15:8]);
			wr(1'b0, 4'h9, {4'h0, r[19:16]});
			chk({ioe, io}, {r[19:18], r[7:0], r[17:16], r[15:8]});
			rdc(1'b0, 4'hB, r[15:8]);
		end
		stream(1'b0);
		stream(1'b1);
		for (int b = 0; b < 2; b++) begin
			wr(b[0], 4'h2, 8'h23);
			wr(b[0], 4'h3, 8'h31);
		end
		phase(1'b0, 546);
		phase(1'b1, 546);
		wr(1'b0, 4'h1, 8'h20);
		rdc(1'b0, 4'h1, 8'h3F);
		phase(1'b0, 1090);
		stream(1'b0);
		for (int b = 0; b < 5; b++) begin
			cerr <= 5'(1 << b);
			@(posedge mclk_i);
			cerr <= 5'h00;
			@(posedge mclk_i);
			chk(err_n, 1'b0);
			rdc(1'b1, 4'hD, 8'(1 << b));
			chk(err_n, 1'b1);
		end
		rdc(1'b1, 4'hD, 8'h00);
		wr(1'b1, 4'h8, 8'h02);
		for (int k = 0; k < 2; k++) begin
			perr <= 1'b1;
			@(posedge mclk_i);
			perr <= 1'b0;
			@(posedge mclk_i);
			chk(err_n, k[0] ? 1'b0 : 1'b1);
		end
		rdc(1'b1, 4'hA, 8'h02);
		chk(err_n, 1'b1);
		wr(1'b1, 4'h4, 8'h21);
		berr <= 1'b1;
		@(posedge mclk_i);
		berr <= 1'b0;
		@(posedge mclk_i);
		chk(err_n, 1'b0);
		rdc(1'b1, 4'hC, 8'h01);
		chk(err_n, 1'b0);
		wr(1'b1, 4'h4, 8'h20);
		@(posedge mclk_i);
		chk(err_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			pll  <= i[1];
			algn <= i[0];
			repeat (2) @(posedge mclk_i);
			chk(lock, i == 3);
			rdc(1'b0, 4'hE, {7'h00, i == 3});
		end
		glitch(1, 1'b0);
		for (int b = 0; b < 3; b++) begin
			wr(1'b0, 4'h8, 8'(b));
			glitch(6, 1'b1);
		end
		conclude();
	end

	initial begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
